// ==== ets_pkg.sv ====
// Package: constants, register map and carrier types of the trigger pulse shaper
// What this block does
// - Only external input edges create trigger pulses
// - Any front input selectable, shared by cameras
// - Falling edge polarity triggers on falling edges
// - Input pulse length ignored, only edges
// - Rate limit rejects pulses above max rate
// - Lost pulses counted, readable, raised as event
// - Optional queue holds excess pulses, releases later
// - Each shaper emits pulse, width in microseconds
// - Each shaper delays pulse start in microseconds
// - Several shapers share trigger, own settings
// - Camera link follows selected shaper edges
// - Front outputs routable to any shaper
// - No outputs until run control set active
// - Input and output pulse tallies readable
// - Graceful halt finishes current pulse, then stops
// - One lost-pulse event per lost pulse
package ets_pkg;
  // Clock and time base
  localparam int CLK_HZ = 10_000_000;
  localparam int US_NS = 1000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int US_CYCLES = US_NS / CLK_NS;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RATE = 8'h04;
  localparam logic [7:0] OFF_ROUTE = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_ST = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_LOST = 8'h18;
  localparam logic [7:0] OFF_IN_TALLY = 8'h1c;
  localparam logic [7:0] OFF_OUT_TALLY = 8'h20;
  localparam logic [7:0] OFF_SHP_BASE = 8'h40;
  // Control field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_HALT = 1;
  localparam int CTRL_POL = 2;
  localparam int CTRL_QUEUE = 3;
  localparam int CTRL_PIN_LSB = 4;
  // Status field positions
  localparam int STAT_ACTIVE = 0;
  localparam int STAT_QCOUNT_LSB = 8;
  // Interrupt bits
  localparam int IRQ_LOST = 0;
  localparam int IRQ_OUT = 1;
  localparam int IRQ_BITS = 2;
  // Reset values
  localparam logic [31:0] RATE_RST = 32'h0000_0000;
  localparam logic [15:0] WIDTH_RST = 16'h0000;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  // Run control states
  typedef enum logic [1:0] {
    ETS_IDLE,
    ETS_ACTIVE,
    ETS_HALTING
  } ets_run_t;
  // Shaper settings carrier
  typedef struct packed {
    logic [15:0] width_us;
    logic [15:0] delay_us;
  } ets_shape_cfg_t;
endpackage

// ==== ets_shaper.sv ====
// Module: one pulse form generator with delay and width in microseconds
module ets_shaper (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Timing
  input wire logic us_tick,
  input wire ets_pkg::ets_shape_cfg_t cfg,
  // Trigger and state
  input wire logic fire,
  output logic pulse,
  output logic busy
);
  typedef enum logic [1:0] {SH_IDLE, SH_DELAY, SH_HIGH} ets_sh_t;
  ets_sh_t st_r, st_nxt; // Phase
  logic [15:0] cnt_r, cnt_nxt; // Microsecond count
  // Next state: a trigger during a pulse is ignored
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      SH_IDLE: begin
        if (fire) begin
          cnt_nxt = 16'h0000;
          st_nxt = (cfg.delay_us == 16'h0000) ? SH_HIGH : SH_DELAY;
        end
      end
      SH_DELAY: begin
        if (us_tick) begin
          cnt_nxt = cnt_r + 16'h0001;
          if (cnt_r + 16'h0001 >= cfg.delay_us) begin
            cnt_nxt = 16'h0000;
            st_nxt = SH_HIGH;
          end
        end
      end
      SH_HIGH: begin
        if (us_tick) begin
          cnt_nxt = cnt_r + 16'h0001;
          if (cnt_r + 16'h0001 >= cfg.width_us) begin
            st_nxt = SH_IDLE;
          end
        end
      end
    endcase
  end
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= SH_IDLE;
      cnt_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  assign pulse = (st_r == SH_HIGH);
  assign busy = (st_r != SH_IDLE);
endmodule

// ==== ets_top.sv ====
// Module: external trigger path with rate valve, queue, shapers and APB registers
//
// Decided for this implementation: the placing of the registers and register access over APB.
module ets_top #(
  parameter int N_PINS = 4,
  parameter int N_SHP = 2,
  parameter int N_OUT = 2,
  parameter int QW = 4
) (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger pins
  input wire logic [N_PINS-1:0] front_in,
  output logic camera_link_trig,
  output logic [N_OUT-1:0] front_out,
  // Interrupt
  output logic irq
);
  localparam int PW = (N_PINS > 1) ? $clog2(N_PINS) : 1;
  localparam int SW = (N_SHP > 1) ? $clog2(N_SHP) : 1;
  // Elaboration checks
  initial begin
    if (N_PINS < 1 || N_PINS > 16 || N_SHP < 1 || N_SHP > 8 || N_OUT < 1 || N_OUT > 8 || QW < 1 || QW > 16)
      $error("ets_top: unsupported parameter values");
  end

  // Software state
  logic run_req_r, run_req_nxt; // Run request written by software
  logic halt_req_r, halt_req_nxt; // Graceful halt request
  logic input_edge_polarity_r, pol_nxt; // 1 = falling_edge_active
  logic queue_en_r, queue_en_nxt; // Queue excess pulses
  logic [PW-1:0] input_pin_select_r, pin_nxt;
  logic [31:0] max_pulse_rate_r, rate_nxt; // Minimum period in clock cycles
  logic [SW-1:0] camera_link_rise_select_r, rise_nxt;
  logic [SW-1:0] camera_link_fall_select_r, fall_nxt;
  logic [N_OUT*SW-1:0] front_route_r, route_nxt; // front_out0_route, front_out1_route...
  ets_pkg::ets_shape_cfg_t [N_SHP-1:0] shp_cfg_r, shp_cfg_nxt;
  logic [ets_pkg::IRQ_BITS-1:0] irq_st_r, irq_st_nxt, irq_mask_r, irq_mask_nxt;
  logic [31:0] prdata_nxt;
  // Datapath state
  ets_pkg::ets_run_t run_st_r, run_st_nxt;
  logic pin_d_r; // Previous sample of selected pin
  logic [31:0] gap_r, gap_nxt; // Cycles since last fired pulse
  logic [QW:0] qcnt_r, qcnt_nxt; // Queued pulses
  logic [31:0] lost_pulse_count_r, lost_nxt;
  logic [31:0] input_pulse_tally_r, in_tally_nxt;
  logic [31:0] output_pulse_tally_r, out_tally_nxt;
  logic [7:0] us_div_r, us_div_nxt;
  logic us_tick_r;
  logic cam_r, cam_nxt;
  logic [N_OUT-1:0] fout_r, fout_nxt;
  // Shaper wires
  logic [N_SHP-1:0] shp_pulse, shp_busy, shp_pulse_d_r;
  logic fire;

  // Bus decode: single wait-free access phase
  logic wr_en, rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite; // Read data registered at setup, stands in access
  logic addr_ok;
  logic [7:0] shp_off;
  assign shp_off = paddr - ets_pkg::OFF_SHP_BASE;
  always_comb begin
    unique case (paddr)
      ets_pkg::OFF_CTRL, ets_pkg::OFF_RATE, ets_pkg::OFF_ROUTE, ets_pkg::OFF_STAT,
      ets_pkg::OFF_IRQ_ST, ets_pkg::OFF_IRQ_MASK, ets_pkg::OFF_LOST,
      ets_pkg::OFF_IN_TALLY, ets_pkg::OFF_OUT_TALLY: addr_ok = 1'b1;
      default: addr_ok = (paddr >= ets_pkg::OFF_SHP_BASE) && (shp_off[1:0] == 2'b00) &&
                         ({2'b00, shp_off[7:2]} < 8'(N_SHP));
    endcase
  end

  // Edge detection on the selected pin; level length plays no part
  logic pin_now, edge_seen, accept, lost_ev, period_ok, running;
  assign pin_now = front_in[input_pin_select_r];
  assign edge_seen = input_edge_polarity_r ? (pin_d_r && !pin_now) : (!pin_d_r && pin_now);
  assign running = (run_st_r == ets_pkg::ETS_ACTIVE);
  assign period_ok = (gap_r >= max_pulse_rate_r);
  // Fire from edge or queue; no internal generator exists in this path
  always_comb begin
    fire = 1'b0;
    accept = 1'b0;
    lost_ev = 1'b0;
    qcnt_nxt = qcnt_r;
    gap_nxt = (gap_r == 32'hffff_ffff) ? gap_r : gap_r + 32'h0000_0001;
    if (running) begin
      if (period_ok && (qcnt_r != '0)) begin
        fire = 1'b1;
        qcnt_nxt = qcnt_r - 1'b1;
      end else if (period_ok && edge_seen) begin
        fire = 1'b1;
      end
      if (edge_seen) begin
        accept = !fire || (qcnt_r != '0) ? 1'b0 : 1'b1;
        if (!(fire && qcnt_r == '0)) begin
          if (queue_en_r && (qcnt_nxt < (QW+1)'(1 << QW) - 1'b1)) begin
            qcnt_nxt = qcnt_nxt + 1'b1;
            accept = 1'b1;
          end else begin
            lost_ev = 1'b1;
          end
        end
      end
      if (fire) gap_nxt = 32'h0000_0001;
    end else begin
      qcnt_nxt = '0;
    end
  end

  // Shaper instances
  logic [N_SHP-1:0] rise_ev, fall_ev;
  genvar gi;
  generate
    for (gi = 0; gi < N_SHP; gi++) begin : g_shp
      ets_shaper u_shp (
        .pclk(pclk),
        .presetn(presetn),
        .us_tick(us_tick_r),
        .cfg(shp_cfg_r[gi]),
        .fire(fire),
        .pulse(shp_pulse[gi]),
        .busy(shp_busy[gi])
      );
      assign rise_ev[gi] = shp_pulse[gi] && !shp_pulse_d_r[gi];
      assign fall_ev[gi] = !shp_pulse[gi] && shp_pulse_d_r[gi];
    end
  endgenerate

  // Run control, halt, tallies, outputs
  always_comb begin
    run_st_nxt = run_st_r;
    unique case (run_st_r)
      ets_pkg::ETS_IDLE: if (run_req_r && !halt_req_r) run_st_nxt = ets_pkg::ETS_ACTIVE;
      ets_pkg::ETS_ACTIVE: if (halt_req_r || !run_req_r) run_st_nxt = ets_pkg::ETS_HALTING;
      ets_pkg::ETS_HALTING: if (shp_busy == '0) run_st_nxt = ets_pkg::ETS_IDLE;
      default: run_st_nxt = ets_pkg::ETS_IDLE;
    endcase
    lost_nxt = lost_pulse_count_r + (lost_ev ? 32'h1 : 32'h0);
    in_tally_nxt = input_pulse_tally_r + (accept ? 32'h1 : 32'h0);
    out_tally_nxt = output_pulse_tally_r + (rise_ev[0] ? 32'h1 : 32'h0);
    // Camera link: rise from the rise-selected shaper, fall from the fall-selected one, which may be the same
    cam_nxt = cam_r;
    if (fall_ev[camera_link_fall_select_r]) cam_nxt = 1'b0;
    if (rise_ev[camera_link_rise_select_r]) cam_nxt = 1'b1;
    if (run_st_r == ets_pkg::ETS_IDLE) cam_nxt = 1'b0;
    for (int i = 0; i < N_OUT; i++)
      fout_nxt[i] = shp_pulse[front_route_r[i*SW +: SW]];
    us_div_nxt = (us_div_r == 8'(ets_pkg::US_CYCLES - 1)) ? 8'h00 : us_div_r + 8'h01;
    // Restart the time base on a trigger that finds every shaper idle, so delay and width are whole microseconds
    if (fire && shp_busy == '0) us_div_nxt = 8'h00;
  end

  // Register writes, sticky interrupts (set beats clear)
  always_comb begin
    run_req_nxt = run_req_r;
    halt_req_nxt = halt_req_r;
    pol_nxt = input_edge_polarity_r;
    queue_en_nxt = queue_en_r;
    pin_nxt = input_pin_select_r;
    rate_nxt = max_pulse_rate_r;
    rise_nxt = camera_link_rise_select_r;
    fall_nxt = camera_link_fall_select_r;
    route_nxt = front_route_r;
    shp_cfg_nxt = shp_cfg_r;
    irq_mask_nxt = irq_mask_r;
    irq_st_nxt = irq_st_r;
    if (wr_en) begin
      unique case (paddr)
        ets_pkg::OFF_CTRL: begin
          run_req_nxt = pwdata[ets_pkg::CTRL_RUN];
          halt_req_nxt = pwdata[ets_pkg::CTRL_HALT];
          pol_nxt = pwdata[ets_pkg::CTRL_POL];
          queue_en_nxt = pwdata[ets_pkg::CTRL_QUEUE];
          pin_nxt = pwdata[ets_pkg::CTRL_PIN_LSB +: PW];
        end
        ets_pkg::OFF_RATE: rate_nxt = pwdata;
        ets_pkg::OFF_ROUTE: begin
          rise_nxt = pwdata[SW-1:0];
          fall_nxt = pwdata[8 +: SW];
          route_nxt = pwdata[16 +: N_OUT*SW];
        end
        ets_pkg::OFF_IRQ_ST: irq_st_nxt = irq_st_r & ~pwdata[ets_pkg::IRQ_BITS-1:0];
        ets_pkg::OFF_IRQ_MASK: irq_mask_nxt = pwdata[ets_pkg::IRQ_BITS-1:0];
        default: if (addr_ok && paddr >= ets_pkg::OFF_SHP_BASE)
          shp_cfg_nxt[shp_off[2+:SW]] = pwdata;
      endcase
    end
    if (lost_ev) irq_st_nxt[ets_pkg::IRQ_LOST] = 1'b1;
    if (rise_ev[0]) irq_st_nxt[ets_pkg::IRQ_OUT] = 1'b1;
    prdata_nxt = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        ets_pkg::OFF_CTRL: prdata_nxt = 32'({input_pin_select_r, queue_en_r, input_edge_polarity_r,
                                               halt_req_r, run_req_r});
        ets_pkg::OFF_RATE: prdata_nxt = max_pulse_rate_r;
        ets_pkg::OFF_ROUTE: prdata_nxt = 32'(front_route_r) << 16 | 32'(camera_link_fall_select_r) << 8 |
                                         32'(camera_link_rise_select_r);
        ets_pkg::OFF_STAT: prdata_nxt = 32'(qcnt_r) << ets_pkg::STAT_QCOUNT_LSB |
                                        32'(run_st_r != ets_pkg::ETS_IDLE);
        ets_pkg::OFF_IRQ_ST: prdata_nxt = 32'(irq_st_r);
        ets_pkg::OFF_IRQ_MASK: prdata_nxt = 32'(irq_mask_r);
        ets_pkg::OFF_LOST: prdata_nxt = lost_pulse_count_r;
        ets_pkg::OFF_IN_TALLY: prdata_nxt = input_pulse_tally_r;
        ets_pkg::OFF_OUT_TALLY: prdata_nxt = output_pulse_tally_r;
        default: if (addr_ok) prdata_nxt = shp_cfg_r[shp_off[2+:SW]];
      endcase
    end
  end

  // Flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_req_r <= 1'b0;
      halt_req_r <= 1'b0;
      input_edge_polarity_r <= 1'b0;
      queue_en_r <= 1'b0;
      input_pin_select_r <= '0;
      max_pulse_rate_r <= ets_pkg::RATE_RST;
      camera_link_rise_select_r <= '0;
      camera_link_fall_select_r <= '0;
      front_route_r <= '0;
      shp_cfg_r <= '{default: '{width_us: ets_pkg::WIDTH_RST, delay_us: ets_pkg::DELAY_RST}};
      irq_st_r <= '0;
      irq_mask_r <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      run_st_r <= ets_pkg::ETS_IDLE;
      pin_d_r <= 1'b0;
      gap_r <= 32'hffff_ffff;
      qcnt_r <= '0;
      lost_pulse_count_r <= 32'h0;
      input_pulse_tally_r <= 32'h0;
      output_pulse_tally_r <= 32'h0;
      us_div_r <= 8'h00;
      us_tick_r <= 1'b0;
      shp_pulse_d_r <= '0;
      cam_r <= 1'b0;
      fout_r <= '0;
      camera_link_trig <= 1'b0;
      front_out <= '0;
    end else begin
      run_req_r <= run_req_nxt;
      halt_req_r <= halt_req_nxt;
      input_edge_polarity_r <= pol_nxt;
      queue_en_r <= queue_en_nxt;
      input_pin_select_r <= pin_nxt;
      max_pulse_rate_r <= rate_nxt;
      camera_link_rise_select_r <= rise_nxt;
      camera_link_fall_select_r <= fall_nxt;
      front_route_r <= route_nxt;
      shp_cfg_r <= shp_cfg_nxt;
      irq_st_r <= irq_st_nxt;
      irq_mask_r <= irq_mask_nxt;
      prdata <= prdata_nxt;
      pready <= psel && !penable; // Answer in the cycle after setup
      pslverr <= psel && !penable && !addr_ok;
      irq <= |(irq_st_nxt & irq_mask_nxt);
      run_st_r <= run_st_nxt;
      pin_d_r <= pin_now;
      gap_r <= gap_nxt;
      qcnt_r <= qcnt_nxt;
      lost_pulse_count_r <= lost_nxt;
      input_pulse_tally_r <= in_tally_nxt;
      output_pulse_tally_r <= out_tally_nxt;
      us_div_r <= us_div_nxt;
      us_tick_r <= (us_div_nxt == 8'(ets_pkg::US_CYCLES - 1));
      shp_pulse_d_r <= shp_pulse;
      cam_r <= cam_nxt;
      fout_r <= fout_nxt;
      camera_link_trig <= cam_nxt;
      front_out <= fout_nxt;
    end
  end
endmodule

// ==== ets_properties.sv ====
// Port checker of the external trigger pulse shaper
module ets_properties #(
  parameter int N_PINS = 4,
  parameter int N_OUT = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Trigger pins
  input wire logic [N_PINS-1:0] front_in,
  input wire logic camera_link_trig,
  input wire logic [N_OUT-1:0] front_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_hit; // Write landing at this edge
  logic run_r, run_nxt; // Run ever requested
  logic edge_r, edge_nxt; // Any input change seen
  logic [N_PINS-1:0] fin_r; // Previous input sample
  logic [15:0] w0_r, w0_nxt; // Shadow of shaper zero width
  int hi_r, hi_nxt; // Camera high run length
  assign wr_hit = psel && penable && pready && pwrite;
  // Shadow only what the properties need, not the whole map
  always_comb begin
    run_nxt = run_r || (wr_hit && paddr == ets_pkg::OFF_CTRL && pwdata[ets_pkg::CTRL_RUN]);
    edge_nxt = edge_r || (front_in != fin_r);
    w0_nxt = (wr_hit && paddr == ets_pkg::OFF_SHP_BASE) ? pwdata[31:16] : w0_r;
    hi_nxt = camera_link_trig ? hi_r + 1 : 0;
  end
  // Register the shadows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
      edge_r <= 1'b0;
      fin_r <= '1;
      w0_r <= ets_pkg::WIDTH_RST;
      hi_r <= 0;
    end else begin
      run_r <= run_nxt;
      edge_r <= edge_nxt;
      fin_r <= front_in;
      w0_r <= w0_nxt;
      hi_r <= hi_nxt;
    end
  end
  ready_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  quiet_start_a: assert property (!run_r |-> !camera_link_trig && front_out == '0)
    else $error("output before run");
  edge_origin_a: assert property ($rose(camera_link_trig) |-> edge_r)
    else $error("trigger without input edge");
  width_exact_a: assert property ($fell(camera_link_trig) |->
    hi_r == ((w0_r == 16'h0) ? 1 : int'(w0_r)) * ets_pkg::US_CYCLES)
    else $error("camera pulse width wrong");
endmodule
bind ets_top ets_properties #(.N_PINS(N_PINS), .N_OUT(N_OUT)) u_ets_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .front_in(front_in),
  .camera_link_trig(camera_link_trig), .front_out(front_out));

// ==== ets_barrier.sv ====
// Light barrier on a front input, observer of camera and flash
module ets_barrier (
  // Clock
  input wire logic pclk,
  // Barrier request
  input wire logic go,
  input wire logic [1:0] pin,
  input wire logic [15:0] low_cyc,
  output logic [3:0] front_in,
  // Observed outputs
  input wire logic cam,
  input wire logic flash,
  output int cam_rises,
  output int cam_dly,
  output int cam_w,
  output int flash_w
);
  timeunit 1ns;
  timeprecision 1ns;
  int lo = 0; // Cycles left low
  int t = 0; // Cycles since barrier edge
  int cw = 0, fw = 0; // High run lengths
  // Idle lines rest high, as behind a pull-up
  initial begin
    front_in = 4'hf;
    cam_rises = 0;
  end
  // Barrier goes low for low_cyc cycles, then releases
  always @(posedge pclk) begin
    t <= t + 1;
    cw <= cam ? cw + 1 : 0;
    fw <= flash ? fw + 1 : 0;
    if (go) begin
      front_in[pin] <= 1'b0;
      lo <= low_cyc;
      t <= 0;
    end else if (lo > 1) begin
      lo <= lo - 1;
    end else if (lo == 1) begin
      lo <= 0;
      front_in <= 4'hf;
    end
    if (cam && cw == 0) begin
      cam_rises <= cam_rises + 1;
      cam_dly <= t;
    end
    if (!cam && cw != 0) cam_w <= cw;
    if (!flash && fw != 0) flash_w <= fw;
  end
endmodule

// ==== external_trigger_pulse_shaper_tb_top.sv ====
// Self-checking bench of the external trigger pulse shaper
module external_trigger_pulse_shaper_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, pready, pslverr, irq, cam, err; // Clock, outputs
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0; // Inputs
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] front_in;
  logic [1:0] fout, pin = 2'h0;
  logic [15:0] low_cyc = 16'h0;
  int n_fail = 0, num_checks = 0, cam_rises, cam_dly, cam_w, flash_w, c0;
  ets_top i_ets_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .front_in(front_in), .camera_link_trig(cam), .front_out(fout), .irq(irq));
  ets_barrier u_barrier (.pclk(pclk), .go(go), .pin(pin), .low_cyc(low_cyc), .front_in(front_in),
    .cam(cam), .flash(fout[0]), .cam_rises(cam_rises), .cam_dly(cam_dly), .cam_w(cam_w),
    .flash_w(flash_w));
  // 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Verdict and end of run
  task automatic final_report();
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Compare seen with expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, answer taken at the ready edge; bounded wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 16) begin
      n_fail++;
      $display("unexpected at %0t: no ready", $time);
      final_report();
    end
  endtask
  // Read and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Barrier edge on pin p, low for lc cycles, then wait gap cycles
  task automatic trig(input logic [1:0] p, input logic [15:0] lc, input int gap);
    go <= 1'b1;
    pin <= p;
    low_cyc <= lc;
    @(posedge pclk);
    go <= 1'b0;
    repeat (gap) @(posedge pclk);
  endtask
  // Reset values, read-only tally, unmapped place
  task automatic t_regs();
    rdc(ets_pkg::OFF_CTRL, 32'h0);
    rdc(ets_pkg::OFF_RATE, ets_pkg::RATE_RST);
    rdc(ets_pkg::OFF_SHP_BASE, {ets_pkg::WIDTH_RST, ets_pkg::DELAY_RST});
    apb(1'b1, ets_pkg::OFF_IN_TALLY, 32'h5);
    rdc(ets_pkg::OFF_IN_TALLY, 32'h0);
    rdc(8'hfc, 32'h0);
    chk(err, 32'h1);
  endtask
  // Quiet before run, then one shaped pulse on camera and flash
  task automatic t_basic();
    apb(1'b1, ets_pkg::OFF_SHP_BASE, {16'h0014, 16'h0005});
    apb(1'b1, ets_pkg::OFF_SHP_BASE + 8'h04, {16'h0019, 16'h0002});
    apb(1'b1, ets_pkg::OFF_ROUTE, 32'h0001_0000);
    apb(1'b1, ets_pkg::OFF_RATE, 32'h0);
    trig(2'h2, 16'h14, 400);
    chk(cam_rises, 0);
    apb(1'b1, ets_pkg::OFF_CTRL, 32'h25);
    trig(2'h2, 16'h258, 1500);
    chk(cam_rises, 1);
    chk(cam_w, 200);
    chk(flash_w, 250);
    chk(cam_dly >= 50 && cam_dly <= 64, 1);
    rdc(ets_pkg::OFF_IN_TALLY, 32'h1);
    rdc(ets_pkg::OFF_OUT_TALLY, 32'h1);
  endtask
  // Rate valve, lost count, interrupt raise, clear and mask
  task automatic t_rate();
    c0 = cam_rises;
    apb(1'b1, ets_pkg::OFF_SHP_BASE, {16'h0001, 16'h0000});
    apb(1'b1, ets_pkg::OFF_RATE, 32'd1000);
    apb(1'b1, ets_pkg::OFF_IRQ_MASK, 32'h1);
    apb(1'b1, ets_pkg::OFF_CTRL, 32'h15);
    trig(2'h1, 16'h5, 300);
    trig(2'h1, 16'h5, 750);
    trig(2'h1, 16'h5, 300);
    chk(cam_rises - c0, 2);
    rdc(ets_pkg::OFF_LOST, 32'h1);
    chk(irq, 32'h1);
    apb(1'b1, ets_pkg::OFF_IRQ_ST, 32'h1);
    repeat (3) @(posedge pclk);
    chk(irq, 32'h0);
    apb(1'b1, ets_pkg::OFF_IRQ_MASK, 32'h0);
    trig(2'h1, 16'h5, 20);
    trig(2'h1, 16'h5, 20);
    chk(irq, 32'h0);
    apb(1'b0, ets_pkg::OFF_IRQ_ST, 32'h0);
    chk(rd[ets_pkg::IRQ_LOST], 32'h1);
    rdc(ets_pkg::OFF_LOST, 32'h3);
  endtask
  // Burst held in the queue and released later
  task automatic t_queue();
    c0 = cam_rises;
    repeat (1100) @(posedge pclk);
    apb(1'b1, ets_pkg::OFF_CTRL, 32'h1d);
    trig(2'h1, 16'h5, 100);
    trig(2'h1, 16'h5, 30);
    apb(1'b0, ets_pkg::OFF_STAT, 32'h0);
    chk(rd[ets_pkg::STAT_QCOUNT_LSB +: 4], 32'h1);
    repeat (1200) @(posedge pclk);
    chk(cam_rises - c0, 2);
    rdc(ets_pkg::OFF_LOST, 32'h3);
  endtask
  // Graceful halt in mid-pulse
  task automatic t_halt();
    apb(1'b1, ets_pkg::OFF_CTRL, 32'h15);
    apb(1'b1, ets_pkg::OFF_RATE, 32'h0);
    apb(1'b1, ets_pkg::OFF_SHP_BASE, {16'h0064, 16'h0000});
    trig(2'h1, 16'h5, 300);
    apb(1'b1, ets_pkg::OFF_CTRL, 32'h16);
    repeat (1000) @(posedge pclk);
    chk(cam_w, 1000);
    rdc(ets_pkg::OFF_STAT, 32'h0);
    c0 = cam_rises;
    trig(2'h1, 16'h5, 1200);
    chk(cam_rises - c0, 0);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_basic();
    t_rate();
    t_queue();
    t_halt();
    final_report();
  end
endmodule
